// ===== rtl/tsc_trap_unit.sv
// module: conditional trap, system-call and synchronize evaluation for the execute stage
// Notes on behaviour
// - register equal trap: function 110100, traps when both source registers are equal
// - immediate equal trap: selector 01100, sign-extended immediate equals source, trap
// - signed greater-or-equal traps, register 110000 or immediate 01000
// - unsigned greater-or-equal traps, 110001 or 01001; immediate still sign-extended
// - ten-bit code field of register traps is ignored by hardware
// - system call, function 001100, traps unconditionally; 20-bit code ignored
// - synchronize, function 001111, is a no-operation raising no exception
// - immediate extended by 16 copies of bit 15 in 32-bit mode, 48 in 64-bit
`timescale 1ns/10ps
module tsc_trap_unit
  import tsc_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // instruction issue from decode
  input  wire logic        i_valid,
  input  wire logic [31:0] i_instr,
  input  wire logic [63:0] i_first_source_register,
  input  wire logic [63:0] i_second_source_register,
  input  wire logic        i_mode64,
  // result towards exception sequencer and writeback
  output logic             o_done,
  output logic             o_trap_exc,
  output logic             o_system_call_exc,
  output logic             o_sync_nop,
  output logic             o_wr_suppress,
  output logic             o_flush_younger
);

  // ****************************************
  // reset release and state
  // ****************************************
  logic [1:0] rst_sync_r;
  logic       rst_n;

  typedef struct packed {
    logic done;
    logic trap;
    logic sys;
    logic sync;
  } tsc_state_t;

  tsc_state_t st_r;
  tsc_state_t st_nxt;

  // two-stage reset release
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_r <= TSC_RST_SYNC;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ****************************************
  // decode and compare
  // ****************************************
  // sign-extend immediate to the mode width
  function automatic logic [63:0] tsc_sext(input logic [15:0] imm, input logic m64);
    logic [63:0] v;
    v = {{48{imm[15]}}, imm};
    if (!m64) begin
      v = {32'h0000_0000, {16{imm[15]}}, imm};
    end
    return v;
  endfunction : tsc_sext

  // narrow to 32-bit view in 32-bit mode (upper bits follow bit 31)
  function automatic logic [63:0] tsc_view(input logic [63:0] x, input logic m64);
    return m64 ? x : {{32{x[31]}}, x[31:0]};
  endfunction : tsc_view

  tsc_kind_t   kind;
  logic        use_imm;
  logic [63:0] opa;
  logic [63:0] opb;
  logic        cond;

  // operation decode; code fields bits 15..6 and 25..6 are never read
  always_comb begin
    kind    = TSC_K_NONE;
    use_imm = 1'b0;
    if (i_instr[TSC_OP_MSB:TSC_OP_LSB] == TSC_OP_FUNCTION) begin
      case (i_instr[TSC_FN_MSB:0])
        TSC_FN_EQ_REG:   kind = TSC_K_EQ;
        TSC_FN_GE_S_REG: kind = TSC_K_GES;
        TSC_FN_GE_U_REG: kind = TSC_K_GEU;
        TSC_FN_SYS_CALL: kind = TSC_K_SYS_CALL;
        TSC_FN_SYNC:     kind = TSC_K_SYNC;
        default:         kind = TSC_K_NONE;
      endcase
    end else if (i_instr[TSC_OP_MSB:TSC_OP_LSB] == TSC_OP_REG_IMM) begin
      use_imm = 1'b1;
      case (i_instr[TSC_SEL_MSB:TSC_SEL_LSB])
        TSC_SEL_EQ_IMM:   kind = TSC_K_EQ;
        TSC_SEL_GE_S_IMM: kind = TSC_K_GES;
        TSC_SEL_GE_U_IMM: kind = TSC_K_GEU;
        default:          kind = TSC_K_NONE;
      endcase
    end
  end

  // operand selection and condition
  always_comb begin
    opa = tsc_view(i_first_source_register, i_mode64);
    opb = use_imm ? tsc_sext(i_instr[TSC_IMM_MSB:0], i_mode64)
                  : tsc_view(i_second_source_register, i_mode64);
    if (!i_mode64) begin
      opb = {{32{opb[31]}}, opb[31:0]};
    end
    case (kind)
      TSC_K_EQ:  cond = (opa == opb);
      TSC_K_GES: cond = ($signed(opa) >= $signed(opb));
      TSC_K_GEU: cond = (opa >= opb);
      default:   cond = 1'b0;
    endcase
  end

  // ****************************************
  // state update
  // ****************************************
  // next state: one-cycle result pulses for each issued instruction
  always_comb begin
    st_nxt      = '0;
    st_nxt.done = i_valid;
    st_nxt.trap = i_valid && cond;
    st_nxt.sys  = i_valid && (kind == TSC_K_SYS_CALL);
    st_nxt.sync = i_valid && (kind == TSC_K_SYNC);
  end

  // result register, cleared by the released reset copy
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{TSC_RST_FLAG, TSC_RST_FLAG, TSC_RST_FLAG, TSC_RST_FLAG};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs: exception kills writeback and younger work
  assign o_done          = st_r.done;
  assign o_trap_exc      = st_r.trap;
  assign o_system_call_exc = st_r.sys;
  assign o_sync_nop      = st_r.sync;
  assign o_wr_suppress   = st_r.trap | st_r.sys;
  assign o_flush_younger = st_r.trap | st_r.sys;

  // ****************************************
  // assertions
  // ****************************************
  property p_teq_reg;
    @(posedge i_core_clk) disable iff (!rst_n)
    (i_valid && i_instr[31:26] == 6'h00 && i_instr[5:0] == 6'h34 && i_mode64 &&
     i_first_source_register == i_second_source_register) |=> o_trap_exc;
  endproperty
  a_teq_reg: assert property (p_teq_reg) else $error("equal register trap missed");

  property p_teq_imm;
    @(posedge i_core_clk) disable iff (!rst_n)
    (i_valid && i_instr[31:26] == 6'h01 && i_instr[20:16] == 5'h0C && i_mode64) |=>
    (o_trap_exc == ($past(i_first_source_register) == {{48{$past(i_instr[15])}}, $past(i_instr[15:0])}));
  endproperty
  a_teq_imm: assert property (p_teq_imm) else $error("equal immediate trap wrong");

  property p_tge_s;
    @(posedge i_core_clk) disable iff (!rst_n)
    (i_valid && i_instr[31:26] == 6'h00 && i_instr[5:0] == 6'h30 && i_mode64) |=>
    (o_trap_exc == ($signed($past(i_first_source_register)) >= $signed($past(i_second_source_register))));
  endproperty
  a_tge_s: assert property (p_tge_s) else $error("signed ge trap wrong");

  property p_tge_u;
    @(posedge i_core_clk) disable iff (!rst_n)
    (i_valid && i_instr[31:26] == 6'h00 && i_instr[5:0] == 6'h31 && i_mode64) |=>
    (o_trap_exc == ($past(i_first_source_register) >= $past(i_second_source_register)));
  endproperty
  a_tge_u: assert property (p_tge_u) else $error("unsigned ge trap wrong");

  property p_sys;
    @(posedge i_core_clk) disable iff (!rst_n)
    (i_valid && i_instr[31:26] == 6'h00 && i_instr[5:0] == 6'h0C) |=> (o_system_call_exc && !o_trap_exc);
  endproperty
  a_sys: assert property (p_sys) else $error("system call not raised");

  property p_sync;
    @(posedge i_core_clk) disable iff (!rst_n)
    (i_valid && i_instr[31:26] == 6'h00 && i_instr[5:0] == 6'h0F) |=>
    (o_sync_nop && !o_trap_exc && !o_system_call_exc);
  endproperty
  a_sync: assert property (p_sync) else $error("synchronize raised exception");

  property p_idle;
    @(posedge i_core_clk) disable iff (!rst_n)
    !i_valid |=> !o_done && !o_trap_exc && !o_system_call_exc;
  endproperty
  a_idle: assert property (p_idle) else $error("event without valid");

  property p_imm32;
    @(posedge i_core_clk) disable iff (!rst_n)
    (i_valid && i_instr[31:26] == 6'h01 && i_instr[20:16] == 5'h0C && !i_mode64 &&
     i_first_source_register[31:0] == {{16{i_instr[15]}}, i_instr[15:0]}) |=> o_trap_exc;
  endproperty
  a_imm32: assert property (p_imm32) else $error("32-bit sign extension wrong");

  property p_kill;
    @(posedge i_core_clk) disable iff (!rst_n)
    (o_trap_exc || o_system_call_exc) |-> (o_wr_suppress && o_flush_younger && o_done);
  endproperty
  a_kill: assert property (p_kill) else $error("exception not precise");

  // system call: issue in one cycle, exception with squash in the next
  sequence s_sys_issue;
    i_valid && i_instr[31:26] == 6'h00 && i_instr[5:0] == 6'h0C;
  endsequence
  sequence s_sys_squash;
    o_system_call_exc && o_wr_suppress && o_flush_younger && o_done;
  endsequence
  property p_sys_squash;
    @(posedge i_core_clk) disable iff (!rst_n)
    s_sys_issue |=> s_sys_squash;
  endproperty
  a_sys_squash: assert property (p_sys_squash) else $error("system call did not squash");

  // unsigned immediate compare still uses the sign-extended immediate
  property p_tge_u_imm;
    @(posedge i_core_clk) disable iff (!rst_n)
    (i_valid && i_instr[31:26] == 6'h01 && i_instr[20:16] == 5'h09 && i_mode64) |=>
    (o_trap_exc == ($past(i_first_source_register) >= {{48{$past(i_instr[15])}}, $past(i_instr[15:0])}));
  endproperty
  a_tge_u_imm: assert property (p_tge_u_imm) else $error("unsigned immediate trap wrong");

  // 32-bit mode signed compare looks at the low words only
  property p_tge_s32;
    @(posedge i_core_clk) disable iff (!rst_n)
    (i_valid && i_instr[31:26] == 6'h00 && i_instr[5:0] == 6'h30 && !i_mode64) |=>
    (o_trap_exc == ($signed($past(i_first_source_register[31:0])) >=
                    $signed($past(i_second_source_register[31:0]))));
  endproperty
  a_tge_s32: assert property (p_tge_s32) else $error("32-bit signed ge trap wrong");

endmodule : tsc_trap_unit

// ===== rtl/tsc_pkg.sv
// package: opcode fields, encodings and reset values for the trap and system-call unit
package tsc_pkg;
  // instruction field positions
  localparam int unsigned TSC_OP_MSB     = 31;
  localparam int unsigned TSC_OP_LSB     = 26;
  localparam int unsigned TSC_SEL_MSB    = 20;
  localparam int unsigned TSC_SEL_LSB    = 16;
  localparam int unsigned TSC_FN_MSB     = 5;
  localparam int unsigned TSC_IMM_MSB    = 15;
  localparam int unsigned TSC_XLEN       = 64;
  localparam int unsigned TSC_HALF       = 32;
  // major opcodes
  localparam logic [5:0] TSC_OP_FUNCTION  = 6'h00;
  localparam logic [5:0] TSC_OP_REG_IMM   = 6'h01;
  // function codes under the function major opcode
  localparam logic [5:0] TSC_FN_EQ_REG    = 6'h34;
  localparam logic [5:0] TSC_FN_GE_S_REG  = 6'h30;
  localparam logic [5:0] TSC_FN_GE_U_REG  = 6'h31;
  localparam logic [5:0] TSC_FN_SYS_CALL  = 6'h0C;
  localparam logic [5:0] TSC_FN_SYNC      = 6'h0F;
  // selectors under the register-immediate major opcode
  localparam logic [4:0] TSC_SEL_EQ_IMM   = 5'h0C;
  localparam logic [4:0] TSC_SEL_GE_S_IMM = 5'h08;
  localparam logic [4:0] TSC_SEL_GE_U_IMM = 5'h09;
  // reset values
  localparam logic       TSC_RST_FLAG    = 1'b0;
  localparam logic [1:0] TSC_RST_SYNC    = 2'h0;

  // decoded operation class
  typedef enum logic [2:0] {
    TSC_K_NONE, TSC_K_EQ, TSC_K_GES, TSC_K_GEU, TSC_K_SYS_CALL, TSC_K_SYNC
  } tsc_kind_t;
endpackage : tsc_pkg

// ===== tb/tsc_decode_model.sv
// partner model: decode stage issuing instructions to the trap unit
`timescale 1ns/10ps
module tsc_decode_model (
  // issue towards the trap unit
  output logic        o_valid,
  output logic [31:0] o_instr,
  output logic [63:0] o_first_source_register,
  output logic [63:0] o_second_source_register,
  output logic        o_mode64
);
  // quiet slot: operands no longer held, so show the inverse of the last value
  task automatic idle();
    o_valid = 1'b0;
    o_first_source_register = ~o_first_source_register;
    o_second_source_register = ~o_second_source_register;
  endtask : idle
  // one instruction for one cycle, called just after a falling edge
  task automatic issue(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b, input logic m);
    o_valid = 1'b1;
    o_instr = ins;
    o_first_source_register = a;
    o_second_source_register = b;
    o_mode64 = m;
  endtask : issue
  // values at time zero
  initial begin
    o_valid = 1'b0;
    o_instr = 32'h0;
    o_first_source_register = 64'h0;
    o_second_source_register = 64'h0;
    o_mode64 = 1'b1;
  end
endmodule : tsc_decode_model

// ===== tb/trap_system_call_instr_condition_unit_tb_top.sv
// testbench: random and corner instruction streams against the trap unit
`timescale 1ns/10ps
module trap_system_call_instr_condition_unit_tb_top;
  import tsc_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        vld, m64, done, trap, sys, sync, wsup, flush;
  logic [31:0] ins;
  logic [63:0] ra, rb;
  logic [3:0]  exp_q = 4'h0;
  int          failures = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  // 20 MHz clock and a hang limit
  always #25 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end

  tsc_decode_model u_decode (.o_valid(vld), .o_instr(ins), .o_first_source_register(ra),
    .o_second_source_register(rb), .o_mode64(m64));
  tsc_trap_unit DUT (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_valid(vld), .i_instr(ins),
    .i_first_source_register(ra), .i_second_source_register(rb), .i_mode64(m64), .o_done(done),
    .o_trap_exc(trap), .o_system_call_exc(sys), .o_sync_nop(sync), .o_wr_suppress(wsup),
    .o_flush_younger(flush));

  // ******************************************
  // expectation: {done, trap, system call, sync}
  // ******************************************
  function automatic logic [3:0] want(logic [31:0] w, logic [63:0] a, logic [63:0] b, logic m);
    logic [63:0] x, y;
    logic        f, r, eq, ges, geu;
    f = (w[31:26] == TSC_OP_FUNCTION);
    r = (w[31:26] == TSC_OP_REG_IMM);
    if (r) b = {{48{w[15]}}, w[15:0]};
    x = m ? a : {{32{a[31]}}, a[31:0]};
    y = m ? b : {{32{b[31]}}, b[31:0]};
    eq = (x == y);
    ges = ($signed(x) >= $signed(y));
    geu = (x >= y);
    if (f && w[5:0] == TSC_FN_SYS_CALL) return 4'hA;
    if (f && w[5:0] == TSC_FN_SYNC) return 4'h9;
    if ((f && w[5:0] == TSC_FN_EQ_REG) || (r && w[20:16] == TSC_SEL_EQ_IMM)) return {1'b1, eq, 2'b00};
    if ((f && w[5:0] == TSC_FN_GE_S_REG) || (r && w[20:16] == TSC_SEL_GE_S_IMM)) return {1'b1, ges, 2'b00};
    if ((f && w[5:0] == TSC_FN_GE_U_REG) || (r && w[20:16] == TSC_SEL_GE_U_IMM)) return {1'b1, geu, 2'b00};
    return 4'h8;
  endfunction : want

  // compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one cycle: check last answer, then issue or idle
  task automatic step(input logic go, input logic [31:0] w, input logic [63:0] a, input logic [63:0] b,
                      input logic m);
    @(negedge i_core_clk);
    check({done, trap, sys, sync}, exp_q);
    check({wsup, flush}, {2{exp_q[2] | exp_q[1]}});
    if (go) u_decode.issue(w, a, b, m);
    else u_decode.idle();
    exp_q = go ? want(w, a, b, m) : 4'h0;
  endtask : step

  // verdict and end of run
  task automatic close_out();
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // main sequence: reset, corner cases, random stream
  initial begin
    logic [31:0] w;
    logic [63:0] a, b;
    logic [15:0] t;
    int          k;
    k = $urandom(32'h58c86fdb);
    repeat (10) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    repeat (3) step(1'b0, 32'h0, 64'h0, 64'h0, 1'b1);
    step(1'b1, {6'h00, 20'hFFFFF, TSC_FN_EQ_REG}, 64'h1_0000_0005, 64'h2_0000_0005, 1'b0);
    step(1'b1, {6'h00, 20'hFFFFF, TSC_FN_EQ_REG}, 64'h1_0000_0005, 64'h2_0000_0005, 1'b1);
    step(1'b1, {6'h01, 5'h3, TSC_SEL_GE_U_IMM, 16'h8000}, 64'h7FFF_FFFF_FFFF_FFFF, 64'h0, 1'b1);
    step(1'b1, {6'h01, 5'h3, TSC_SEL_EQ_IMM, 16'hFFFF}, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0, 1'b1);
    step(1'b1, {6'h00, 20'hABCDE, TSC_FN_SYS_CALL}, 64'h0, 64'h1, 1'b1);
    step(1'b1, {6'h00, 20'h00000, TSC_FN_SYNC}, 64'h0, 64'h0, 1'b1);
    for (int n = 0; n < 600; n++) begin
      t = 16'($urandom);
      a = {{48{t[15]}}, t} + 64'($urandom_range(1));
      if ($urandom_range(2) == 0) a = {$urandom, $urandom};
      b = $urandom_range(1) ? {{48{t[15]}}, t} : {$urandom, $urandom};
      k = $urandom_range(8);
      case (k)
        0: w = {6'h00, 20'($urandom), TSC_FN_EQ_REG};
        1: w = {6'h00, 20'($urandom), TSC_FN_GE_S_REG};
        2: w = {6'h00, 20'($urandom), TSC_FN_GE_U_REG};
        3: w = {6'h00, 20'($urandom), TSC_FN_SYS_CALL};
        4: w = {6'h00, 20'h0, TSC_FN_SYNC};
        5: w = {6'h01, 5'($urandom), TSC_SEL_EQ_IMM, t};
        6: w = {6'h01, 5'($urandom), TSC_SEL_GE_S_IMM, t};
        7: w = {6'h01, 5'($urandom), TSC_SEL_GE_U_IMM, t};
        default: w = $urandom;
      endcase
      step($urandom_range(4) != 0, w, a, b, 1'($urandom));
    end
    step(1'b0, 32'h0, 64'h0, 64'h0, 1'b1);
    // mid-run reset while system calls keep being offered: results must clear at once
    step(1'b1, {6'h00, 20'h12345, TSC_FN_SYS_CALL}, 64'h0, 64'h0, 1'b1);
    step(1'b1, {6'h00, 20'h12345, TSC_FN_SYS_CALL}, 64'h0, 64'h0, 1'b1);
    @(negedge i_core_clk);
    check({done, trap, sys, sync}, exp_q);
    i_rst_n = 1'b0;
    @(negedge i_core_clk);
    check({done, trap, sys, sync, wsup, flush}, 6'h00);
    u_decode.idle();
    i_rst_n = 1'b1;
    exp_q = 4'h0;
    repeat (3) step(1'b0, 32'h0, 64'h0, 64'h0, 1'b1);
    step(1'b1, {6'h00, 20'h0, TSC_FN_SYS_CALL}, 64'h0, 64'h0, 1'b1);
    step(1'b0, 32'h0, 64'h0, 64'h0, 1'b1);
    close_out();
  end
endmodule : trap_system_call_instr_condition_unit_tb_top
